/* File: rtl/smf_pkg.sv */
// Constants, field positions and helpers shared by the mode register feature logic
package smf_pkg;

  // Command word as taken from the address pins of a mode register write
  localparam int          MRW_W      = 22;
  localparam int          XW_W       = 23;
  localparam int          XW_EXIT    = 22;
  localparam int          SEL_HI     = 20;
  localparam int          SEL_LO     = 18;
  localparam int          FIELD_W    = 14;
  localparam logic [2:0]  SEL_MR4    = 3'h4;
  localparam logic [2:0]  SEL_MR5    = 3'h5;
  localparam logic [2:0]  SEL_DNU    = 3'h7;

  // Mode register four field positions
  localparam int B4_WPRE    = 12;
  localparam int B4_RPRE    = 11;
  localparam int B4_RTRAIN  = 10;
  localparam int B4_CAL_HI  = 8;
  localparam int B4_CAL_LO  = 6;
  localparam int B4_SOFT_ROW_REPAIR    = 5;
  localparam int B4_TCR     = 3;
  localparam int B4_TCR_RNG = 2;
  localparam int B4_MPSM    = 1;

  // Mode register five field positions
  localparam int B5_RDBI    = 12;
  localparam int B5_WDBI    = 11;
  localparam int B5_DM      = 10;
  localparam int B5_PERSIST = 9;
  localparam int B5_PARK_HI = 8;
  localparam int B5_PARK_LO = 6;
  localparam int B5_ODTBUF  = 5;
  localparam int B5_PERR    = 4;
  localparam int B5_CRCERR  = 3;
  localparam int B5_PLAT_HI = 2;
  localparam int B5_PLAT_LO = 0;

  // Values after reset
  localparam logic [FIELD_W-1:0] MR4_RST = 14'h0000;
  localparam logic [FIELD_W-1:0] MR5_RST = 14'h0000;

  // Multipurpose readout, page 2 location 0
  localparam int         MPR_SOFT_ROW_REPAIR_BIT = 6;
  localparam logic       SOFT_ROW_REPAIR_AVAIL   = 1'b1;
  localparam logic [7:0] MPR_P2L0_RST = 8'h00;

  // Soft repair storage and device width
  localparam int NBANK    = 16;
  localparam int BANK_W   = 4;
  localparam int ROW_W    = 18;
  localparam int DQ_WIDTH = 8;

  // Refresh skipping while cool: one of this many refreshes is executed
  localparam logic [3:0] TCR_SKIP_RATIO = 4'h2;

  // Longest command address latency in clocks
  localparam int CAL_DEPTH = 8;

  typedef enum logic [1:0] {
    SMF_RUN  = 2'b00,
    SMF_SAVE = 2'b01
  } smf_pwr_e;

  // Latency code to clocks; reserved codes read as off
  function automatic logic [3:0] smf_cal_clocks(input logic [2:0] code);
    unique case (code)
      3'h1:    smf_cal_clocks = 4'h3;
      3'h2:    smf_cal_clocks = 4'h4;
      3'h3:    smf_cal_clocks = 4'h5;
      3'h4:    smf_cal_clocks = 4'h6;
      3'h5:    smf_cal_clocks = 4'h8;
      default: smf_cal_clocks = 4'h0;
    endcase
  endfunction : smf_cal_clocks

endpackage : smf_pkg

/* File: rtl/smf_cal_capture.sv */
// Takes command and address pins a programmed number of clocks after chip select
`timescale 1ns/1ps
module smf_cal_capture (
  // Link clock and reset
  input  wire logic                      i_ck,
  input  wire logic                      i_nrst,
  // Latency in clocks, zero is off
  input  wire logic [3:0]                i_cal,
  // Pins
  input  wire logic                      i_cs_n,
  input  wire logic                      i_act_n,
  input  wire logic                      i_ras_n,
  input  wire logic                      i_cas_n,
  input  wire logic                      i_we_n,
  input  wire logic [smf_pkg::MRW_W-1:0] i_addr,
  // Captured command
  output logic                           o_valid,
  output logic [3:0]                     o_ctl,
  output logic [smf_pkg::MRW_W-1:0]      o_addr
);

  logic [smf_pkg::CAL_DEPTH:1] pend;
  logic [smf_pkg::CAL_DEPTH:0] tap;
  wire  logic                  cs_low = ~i_cs_n;
  wire  logic                  take;

  assign tap  = {pend, cs_low};
  assign take = tap[i_cal];

  // One chip select low per slot; latency change mid-flight may drop a command
  always_ff @(posedge i_ck) begin
    if (!i_nrst) begin
      pend    <= '0;
      o_valid <= 1'b0;
      o_ctl   <= 4'hf;
      o_addr  <= '0;
    end else begin
      pend    <= {pend[smf_pkg::CAL_DEPTH-1:1], cs_low};
      o_valid <= take;
      if (take) begin
        o_ctl  <= {i_act_n, i_ras_n, i_cas_n, i_we_n};
        o_addr <= i_addr;
      end
    end
  end

endmodule : smf_cal_capture

/* File: rtl/smf_word_sync.sv */
// Toggle handshake carrying one word from the link clock to the core clock
`timescale 1ns/1ps
module smf_word_sync (
  // Source side
  input  wire logic                     i_src_clk,
  input  wire logic                     i_src_nrst,
  input  wire logic                     i_src_send,
  input  wire logic [smf_pkg::XW_W-1:0] i_src_data,
  output logic                          o_src_busy,
  // Destination side
  input  wire logic                     i_dst_clk,
  input  wire logic                     i_dst_nrst,
  input  wire logic                     i_dst_ce,
  output logic                          o_dst_valid,
  output logic [smf_pkg::XW_W-1:0]      o_dst_data
);

  logic                      req;
  logic [smf_pkg::XW_W-1:0]  hold;
  logic [1:0]                ack_s;
  logic [2:0]                req_s;
  logic                      ack;
  wire  logic                dst_new = req_s[2] ^ req_s[1];

  assign o_src_busy = req ^ ack_s[1];

  // Held word stays stable until the acknowledge returns
  always_ff @(posedge i_src_clk) begin
    if (!i_src_nrst) begin
      req   <= 1'b0;
      hold  <= '0;
      ack_s <= 2'b00;
    end else begin
      ack_s <= {ack_s[0], ack};
      if (i_src_send && !o_src_busy) begin
        req  <= ~req;
        hold <= i_src_data;
      end
    end
  end

  always_ff @(posedge i_dst_clk) begin
    if (!i_dst_nrst) begin
      req_s       <= 3'b000;
      ack         <= 1'b0;
      o_dst_valid <= 1'b0;
      o_dst_data  <= '0;
    end else if (i_dst_ce) begin
      req_s       <= {req_s[1:0], req};
      o_dst_valid <= dst_new;
      if (dst_new) begin
        o_dst_data <= hold;
        ack        <= req_s[1];
      end
    end
  end

endmodule : smf_word_sync

/* File: rtl/smf_mode_regs.sv */
// Mode register four and five feature logic of the memory device
`timescale 1ns/1ps
module smf_mode_regs (
  // Core clock, reset, enable
  input  wire logic                          i_clk,
  input  wire logic                          i_nrst,
  input  wire logic                          i_ce,
  // Link clock and command pins
  input  wire logic                          i_ck,
  input  wire logic                          i_cs_n,
  input  wire logic                          i_act_n,
  input  wire logic                          i_ras_n,
  input  wire logic                          i_cas_n,
  input  wire logic                          i_we_n,
  input  wire logic [1:0]                    i_bank_group_pins,
  input  wire logic [1:0]                    i_bank_select_pins,
  input  wire logic                          i_a17,
  input  wire logic [13:0]                   i_a,
  // Core events and status
  input  wire logic                          i_parity_err,
  input  wire logic                          i_crc_err,
  input  wire logic                          i_geardown,
  input  wire logic                          i_mpr_read,
  input  wire logic                          i_write_op,
  input  wire logic                          i_power_down,
  input  wire logic                          i_temp_cool,
  input  wire logic                          i_refresh_cmd,
  // Soft repair requests
  input  wire logic                          i_repair_req,
  input  wire logic [smf_pkg::BANK_W-1:0]    i_repair_bank,
  input  wire logic [smf_pkg::ROW_W-1:0]     i_repair_row,
  input  wire logic [smf_pkg::BANK_W-1:0]    i_query_bank,
  // Register views
  output logic [smf_pkg::FIELD_W-1:0]        o_mode_reg_four,
  output logic [smf_pkg::FIELD_W-1:0]        o_mode_reg_five,
  output logic [7:0]                         o_multipurpose_readout_reg,
  // Decoded features
  output logic                               o_write_strobe_lead_2ck,
  output logic                               o_read_lead_2ck,
  output logic                               o_read_lead_training,
  output logic [3:0]                         o_cal_clocks,
  output logic                               o_temp_ctrl_refresh,
  output logic                               o_tcr_extended,
  output logic                               o_power_save,
  output logic                               o_refresh_do,
  output logic                               o_rd_inversion,
  output logic                               o_wr_inversion,
  output logic                               o_write_byte_mask,
  output logic [2:0]                         o_parked_termination_div,
  output logic                               o_die_term_buf_on,
  output logic [2:0]                         o_parity_latency,
  output logic                               o_parity_check_en,
  // Soft repair state
  output logic [smf_pkg::NBANK-1:0]          o_repair_valid,
  output logic [smf_pkg::ROW_W-1:0]          o_repair_row,
  // Link side status
  output logic                               o_cmd_dropped
);

  // ---------------- Link clock domain ----------------
  logic [1:0]                       lrst_s;
  wire  logic                       lnrst = lrst_s[1];
  logic [2:0]                       lcal_code;
  smf_pkg::smf_pwr_e                lpwr;
  smf_pkg::smf_pwr_e                next_lpwr;
  logic                             cap_valid;
  logic [3:0]                       cap_ctl;
  logic [smf_pkg::MRW_W-1:0]        cap_addr;
  logic                             src_busy;
  logic                             send;
  logic [smf_pkg::XW_W-1:0]         send_word;
  wire  logic [smf_pkg::MRW_W-1:0]  pin_word;
  wire  logic                       is_mrs;
  wire  logic                       is_exit;
  wire  logic [2:0]                 cap_sel;
  wire  logic                       mrs_mr4;

  // Bits 16:14 sit under the row, column and write strobes
  assign pin_word = {i_bank_group_pins, i_bank_select_pins, i_a17, 3'h0, i_a};

  // Reset pin reaches the link side through two flops
  always_ff @(posedge i_ck) begin
    lrst_s <= {lrst_s[0], i_nrst};
  end

  smf_cal_capture u_cap (
    .i_ck    (i_ck),
    .i_nrst  (lnrst),
    .i_cal   (smf_pkg::smf_cal_clocks(lcal_code)),
    .i_cs_n  (i_cs_n),
    .i_act_n (i_act_n),
    .i_ras_n (i_ras_n),
    .i_cas_n (i_cas_n),
    .i_we_n  (i_we_n),
    .i_addr  (pin_word),
    .o_valid (cap_valid),
    .o_ctl   (cap_ctl),
    .o_addr  (cap_addr)
  );

  assign cap_sel = cap_addr[smf_pkg::SEL_HI:smf_pkg::SEL_LO];
  assign is_mrs  = cap_valid && cap_ctl == 4'h8 && cap_sel != smf_pkg::SEL_DNU;
  // Exit command: chip select low with all four strobes high
  assign is_exit = cap_valid && cap_ctl == 4'hf;
  assign mrs_mr4 = is_mrs && cap_sel == smf_pkg::SEL_MR4;

  always_comb begin
    next_lpwr = lpwr;
    unique case (lpwr)
      smf_pkg::SMF_RUN:  if (mrs_mr4 && cap_addr[smf_pkg::B4_MPSM]) next_lpwr = smf_pkg::SMF_SAVE;
      smf_pkg::SMF_SAVE: if (is_exit) next_lpwr = smf_pkg::SMF_RUN;
      default:           next_lpwr = smf_pkg::SMF_RUN;
    endcase
  end

  // While saving power only the exit command goes on
  assign send      = (lpwr == smf_pkg::SMF_RUN) ? is_mrs : is_exit;
  assign send_word = {lpwr == smf_pkg::SMF_SAVE, cap_addr};

  // Local latency copy avoids moving a multi-bit field back across clocks
  always_ff @(posedge i_ck) begin
    if (!lnrst) begin
      lpwr          <= smf_pkg::SMF_RUN;
      lcal_code     <= smf_pkg::MR4_RST[smf_pkg::B4_CAL_HI:smf_pkg::B4_CAL_LO];
      o_cmd_dropped <= 1'b0;
    end else begin
      lpwr          <= next_lpwr;
      o_cmd_dropped <= send & src_busy;
      if (mrs_mr4 && lpwr == smf_pkg::SMF_RUN)
        lcal_code <= cap_addr[smf_pkg::B4_CAL_HI:smf_pkg::B4_CAL_LO];
    end
  end

  // ---------------- Core clock domain ----------------
  logic                             rx_valid;
  logic [smf_pkg::XW_W-1:0]         rx_word;

  smf_word_sync u_sync (
    .i_src_clk   (i_ck),
    .i_src_nrst  (lnrst),
    .i_src_send  (send),
    .i_src_data  (send_word),
    .o_src_busy  (src_busy),
    .i_dst_clk   (i_clk),
    .i_dst_nrst  (i_nrst),
    .i_dst_ce    (i_ce),
    .o_dst_valid (rx_valid),
    .o_dst_data  (rx_word)
  );

  logic [smf_pkg::FIELD_W-1:0]      mr4;
  logic [smf_pkg::FIELD_W-1:0]      mr5;
  logic                             par_err;
  logic                             crc_err;
  logic [3:0]                       tcr_cnt;
  logic [smf_pkg::ROW_W-1:0]        rows [smf_pkg::NBANK];
  wire  logic                       rx_exit = rx_valid & rx_word[smf_pkg::XW_EXIT];
  wire  logic                       rx_mrs  = rx_valid & ~rx_word[smf_pkg::XW_EXIT];
  wire  logic [2:0]                 rx_sel  = rx_word[smf_pkg::SEL_HI:smf_pkg::SEL_LO];
  wire  logic                       wr_mr4  = rx_mrs && rx_sel == smf_pkg::SEL_MR4;
  wire  logic                       wr_mr5  = rx_mrs && rx_sel == smf_pkg::SEL_MR5;
  wire  logic [smf_pkg::FIELD_W-1:0] rx_f   = rx_word[smf_pkg::FIELD_W-1:0];
  wire  logic                       wide_ok = smf_pkg::DQ_WIDTH != 4;
  wire  logic                       tcr_skip;
  wire  logic [2:0]                 plat_code;

  // Other mode registers live elsewhere; only four and five are kept here
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mr4 <= smf_pkg::MR4_RST;
      mr5 <= smf_pkg::MR5_RST;
    end else if (i_ce) begin
      if (wr_mr4)
        mr4 <= rx_f;
      else if (rx_exit)
        mr4[smf_pkg::B4_MPSM] <= 1'b0;
      if (wr_mr5)
        mr5 <= rx_f;
    end
  end

  // Sticky errors; a detection in the clearing cycle wins
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      par_err <= smf_pkg::MR5_RST[smf_pkg::B5_PERR];
      crc_err <= smf_pkg::MR5_RST[smf_pkg::B5_CRCERR];
    end else if (i_ce) begin
      if (i_parity_err && o_parity_check_en)
        par_err <= 1'b1;
      else if (wr_mr5)
        par_err <= rx_f[smf_pkg::B5_PERR];
      if (i_crc_err)
        crc_err <= 1'b1;
      else if (wr_mr5)
        crc_err <= rx_f[smf_pkg::B5_CRCERR];
    end
  end

  // Soft repair: one row per bank, dropped on power-down
  genvar gb;
  generate
    for (gb = 0; gb < smf_pkg::NBANK; gb++) begin : g_bank
      wire logic hit = i_repair_req && mr4[smf_pkg::B4_SOFT_ROW_REPAIR] && i_repair_bank == gb;
      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          o_repair_valid[gb] <= 1'b0;
          rows[gb]           <= '0;
        end else if (i_ce) begin
          if (i_power_down)
            o_repair_valid[gb] <= 1'b0;
          else if (hit)
            o_repair_valid[gb] <= 1'b1;
          if (hit && !i_power_down)
            rows[gb] <= i_repair_row;
        end
      end
    end
  endgenerate

  // Temperature refresh: run one of every ratio refreshes while cool
  assign tcr_skip = o_temp_ctrl_refresh && i_temp_cool &&
                    tcr_cnt != smf_pkg::TCR_SKIP_RATIO - 4'h1;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tcr_cnt      <= 4'h0;
      o_refresh_do <= 1'b0;
      o_repair_row <= '0;
      o_multipurpose_readout_reg <= smf_pkg::MPR_P2L0_RST;
    end else if (i_ce) begin
      o_refresh_do <= i_refresh_cmd & ~tcr_skip;
      if (i_refresh_cmd)
        tcr_cnt <= tcr_skip ? tcr_cnt + 4'h1 : 4'h0;
      o_repair_row <= rows[i_query_bank];
      o_multipurpose_readout_reg[smf_pkg::MPR_SOFT_ROW_REPAIR_BIT] <= smf_pkg::SOFT_ROW_REPAIR_AVAIL;
    end
  end

  // Register views and decoded features
  assign o_mode_reg_four = mr4;
  always_comb begin
    o_mode_reg_five                     = mr5;
    o_mode_reg_five[smf_pkg::B5_PERR]   = par_err;
    o_mode_reg_five[smf_pkg::B5_CRCERR] = crc_err;
  end

  assign o_write_strobe_lead_2ck = mr4[smf_pkg::B4_WPRE];
  assign o_read_lead_2ck         = mr4[smf_pkg::B4_RPRE];
  assign o_read_lead_training    = mr4[smf_pkg::B4_RTRAIN];
  assign o_cal_clocks = smf_pkg::smf_cal_clocks(
                          mr4[smf_pkg::B4_CAL_HI:smf_pkg::B4_CAL_LO]);
  assign o_temp_ctrl_refresh     = mr4[smf_pkg::B4_TCR];
  assign o_tcr_extended          = mr4[smf_pkg::B4_TCR_RNG];
  assign o_power_save            = mr4[smf_pkg::B4_MPSM];

  // Byte mask wins a conflict, so write inversion never rides with it
  assign o_rd_inversion    = wide_ok & mr5[smf_pkg::B5_RDBI] & ~i_mpr_read;
  assign o_wr_inversion    = wide_ok & mr5[smf_pkg::B5_WDBI] & ~mr5[smf_pkg::B5_DM];
  assign o_write_byte_mask = wide_ok & mr5[smf_pkg::B5_DM] & i_write_op;
  assign o_die_term_buf_on = ~mr5[smf_pkg::B5_ODTBUF];

  always_comb begin
    unique case (mr5[smf_pkg::B5_PARK_HI:smf_pkg::B5_PARK_LO])
      3'h0: o_parked_termination_div = 3'h0;
      3'h1: o_parked_termination_div = 3'h4;
      3'h2: o_parked_termination_div = 3'h2;
      3'h3: o_parked_termination_div = 3'h6;
      3'h4: o_parked_termination_div = 3'h1;
      3'h5: o_parked_termination_div = 3'h5;
      3'h6: o_parked_termination_div = 3'h3;
      3'h7: o_parked_termination_div = 3'h7;
    endcase
  end

  // Reserved codes, and five clocks in gear-down, leave parity off
  assign plat_code = mr5[smf_pkg::B5_PLAT_HI:smf_pkg::B5_PLAT_LO];
  always_comb begin
    unique case (plat_code)
      3'h1:    o_parity_latency = 3'h4;
      3'h2:    o_parity_latency = i_geardown ? 3'h0 : 3'h5;
      3'h3:    o_parity_latency = 3'h6;
      default: o_parity_latency = 3'h0;
    endcase
  end

  assign o_parity_check_en = o_parity_latency != 3'h0 &&
                             (mr5[smf_pkg::B5_PERSIST] || !par_err);

endmodule : smf_mode_regs

/* File: sim/smf_ctl_model.sv */
// Controller model issuing commands on the memory clock
`timescale 1ns/1ps
module smf_ctl_model (
  // Memory clock
  input  wire logic   i_ck,
  // Command pins
  output logic        o_cs_n,
  output logic        o_rcw_n,
  output logic [4:0]  o_hi,
  output logic [13:0] o_a
);
  initial {o_cs_n, o_rcw_n, o_hi, o_a} = 21'h180000;
  // Chip select first, command cal clocks later
  task automatic send(input logic [4:0] hi, input logic [13:0] a, input logic rcw,
                      input int cal);
    @(posedge i_ck);
    o_cs_n <= 1'b0;
    if (cal > 0) begin
      @(posedge i_ck);
      o_cs_n <= 1'b1;
      repeat (cal - 1) @(posedge i_ck);
    end
    o_rcw_n <= rcw;
    o_hi <= hi;
    o_a <= a;
    @(posedge i_ck);
    o_cs_n <= 1'b1;
    o_rcw_n <= 1'b1;
    // Released lines must not keep their last value
    o_hi <= ~hi;
    o_a <= ~a;
  endtask : send
endmodule : smf_ctl_model

/* File: sim/smf_mode_regs_checker.sv */
// Property checks on the mode register feature outputs
`timescale 1ns/1ps
module smf_mode_regs_checker (
  // Clock, reset and core inputs
  input wire logic        i_clk, i_nrst, i_ce, i_mpr_read, i_write_op,
  input wire logic        i_crc_err, i_geardown, i_power_down,
  // Watched outputs
  input wire logic [13:0] o_mode_reg_five,
  input wire logic        o_rd_inversion, o_wr_inversion, o_write_byte_mask,
  input wire logic [2:0]  o_parked_termination_div, o_parity_latency,
  input wire logic        o_die_term_buf_on,
  input wire logic [15:0] o_repair_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  localparam logic [23:0] PDIV = 24'hee9ca0;
  rd_inv_a: assert property (o_rd_inversion == (o_mode_reg_five[12] & ~i_mpr_read))
    else $error("read inversion wrong");
  wr_inv_a: assert property (o_wr_inversion == (o_mode_reg_five[11:10] == 2'b10))
    else $error("write inversion wrong");
  mask_a: assert property (o_write_byte_mask == (o_mode_reg_five[10] & i_write_op))
    else $error("byte mask wrong");
  park_div_a: assert property (o_parked_termination_div == PDIV[3*o_mode_reg_five[8:6] +: 3])
    else $error("parked divisor wrong");
  term_buf_a: assert property (o_die_term_buf_on != o_mode_reg_five[5])
    else $error("buffer enable wrong");
  crc_sticky_a: assert property (i_crc_err && i_ce |=> o_mode_reg_five[3])
    else $error("write check status not set");
  repair_clr_a: assert property (i_power_down && i_ce |=> o_repair_valid == 16'h0000)
    else $error("repair kept in power-down");
  gear_lat_a: assert property (i_geardown && o_mode_reg_five[2:0] == 3'h2 |->
    o_parity_latency == 3'h0) else $error("latency five in gear-down");
  cover property (o_wr_inversion);
  cover property (o_write_byte_mask);
  cover property (o_repair_valid != 16'h0000);
endmodule : smf_mode_regs_checker
bind smf_mode_regs smf_mode_regs_checker chk_u (.*);

/* File: sim/sdram_mode_reg_feature_decode_test.sv */
// Self-checking bench for the mode register feature logic
`timescale 1ns/1ps
module sdram_mode_reg_feature_decode_test;
  localparam logic [23:0] PDIV = 24'hee9ca0;
  localparam logic [31:0] CALC = 32'h00865430;
  logic        clk = 1'b0, ck = 1'b0, nrst = 1'b0, gear = 1'b0, mprr = 1'b0, wop = 1'b0;
  logic        ce = 1'b1, wpre, rpre, rtrn, temp_ctrl_refresh, tcrx, drop;
  logic        cool = 1'b0, cs_n, rcw_n, rinv, winv, mask, pce, psave, rdo, tbuf;
  logic [4:0]  ev = 5'h00, hi;
  logic [3:0]  rbank = 4'h0, cal;
  logic [17:0] rrow = 18'h00000, rrow_q;
  logic [13:0] a, mr4, mr5;
  logic [7:0]  multipurpose_readout_reg;
  logic [15:0] rvalid;
  logic [2:0]  park, plat;
  int          err_total = 0, n_compared = 0, n_ref = 0, lat = 0, n_drop = 0;
  always #4 clk = ~clk;
  // Memory clock offset so the two domains never line up
  initial begin
    #5;
    forever #24 ck = ~ck;
  end
  always @(posedge clk) if (rdo) n_ref <= n_ref + 1;
  always @(posedge ck) if (drop) n_drop <= n_drop + 1;
  smf_ctl_model m_u (.i_ck(ck), .o_cs_n(cs_n), .o_rcw_n(rcw_n), .o_hi(hi), .o_a(a));
  smf_mode_regs dut_u (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_ck(ck), .i_cs_n(cs_n),
    .i_act_n(1'b1), .i_ras_n(rcw_n), .i_cas_n(rcw_n), .i_we_n(rcw_n),
    .i_bank_group_pins(hi[4:3]), .i_bank_select_pins(hi[2:1]), .i_a17(hi[0]), .i_a(a),
    .i_parity_err(ev[0]), .i_crc_err(ev[1]), .i_geardown(gear), .i_mpr_read(mprr),
    .i_write_op(wop), .i_power_down(ev[4]), .i_temp_cool(cool), .i_refresh_cmd(ev[2]),
    .i_repair_req(ev[3]), .i_repair_bank(rbank), .i_repair_row(rrow), .i_query_bank(rbank),
    .o_mode_reg_four(mr4), .o_mode_reg_five(mr5), .o_multipurpose_readout_reg(multipurpose_readout_reg),
    .o_write_strobe_lead_2ck(wpre), .o_read_lead_2ck(rpre), .o_read_lead_training(rtrn),
    .o_cal_clocks(cal), .o_temp_ctrl_refresh(temp_ctrl_refresh), .o_tcr_extended(tcrx), .o_power_save(psave),
    .o_refresh_do(rdo), .o_rd_inversion(rinv), .o_wr_inversion(winv),
    .o_write_byte_mask(mask), .o_parked_termination_div(park), .o_die_term_buf_on(tbuf),
    .o_parity_latency(plat), .o_parity_check_en(pce), .o_repair_valid(rvalid),
    .o_repair_row(rrow_q), .o_cmd_dropped(drop));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic mw(input logic [2:0] sel, input logic [13:0] v);
    m_u.send({1'b0, sel, 1'b0}, v, 1'b0, lat);
    repeat (30) @(posedge clk);
  endtask : mw
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 5'h00;
    repeat (3) @(posedge clk);
  endtask : pulse
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge ck);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ck);
    @(posedge clk);
    chk({mr4, mr5}, 28'h0);
    chk(tbuf, 1'b1);
    chk(multipurpose_readout_reg[6], 1'b1);
    for (int c = 0; c < 8; c++) begin
      mw(3'h5, {5'h00, c[2:0], 6'h00});
      chk(park, PDIV[3*c +: 3]);
    end
    // Each write goes out with the latency set by the one before
    for (int c = 0; c < 8; c++) begin
      mw(3'h4, {5'h00, c[2:0], 6'h00});
      lat = int'(CALC[4*c +: 4]);
      chk(cal, CALC[4*c +: 4]);
    end
    mw(3'h7, 14'h1fff);
    mw(3'h2, 14'h1fff);
    chk({mr4, mr5}, {14'h01c0, 14'h01c0});
    mw(3'h5, 14'h1a00);
    chk({mr5, rinv, winv}, {14'h1a00, 2'b11});
    mprr <= 1'b1;
    @(posedge clk);
    chk(rinv, 1'b0);
    mprr <= 1'b0;
    mw(3'h5, 14'h0c00);
    wop <= 1'b1;
    @(posedge clk);
    chk({mask, winv}, 2'b10);
    wop <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      mw(3'h5, {11'h000, c[2:0]});
      chk(plat, (c == 0) ? 0 : c + 3);
    end
    mw(3'h5, 14'h0002);
    gear <= 1'b1;
    @(posedge clk);
    chk(plat, 3'h0);
    gear <= 1'b0;
    mw(3'h5, 14'h0001);
    pulse(0);
    chk({mr5, pce}, {14'h0011, 1'b0});
    mw(3'h5, 14'h0211);
    pulse(1);
    chk({mr5, pce}, {14'h0219, 1'b1});
    // Second write follows too closely and is lost at the crossing
    m_u.send(5'h0a, 14'h0004, 1'b0, lat);
    mw(3'h5, 14'h0005);
    chk(mr5, 14'h0004);
    chk(n_drop, 1);
    mw(3'h5, 14'h0000);
    chk(mr5, 14'h0000);
    // Core enable low freezes the status bits
    ce <= 1'b0;
    pulse(1);
    ce <= 1'b1;
    chk(mr5, 14'h0000);
    mw(3'h4, 14'h1c0c);
    chk({wpre, rpre, rtrn, temp_ctrl_refresh, tcrx}, 5'h1f);
    cool <= 1'b1;
    pulse(2);
    pulse(2);
    chk(n_ref, 1);
    cool <= 1'b0;
    pulse(2);
    chk(n_ref, 2);
    mw(3'h4, 14'h0020);
    rbank <= 4'h3;
    rrow <= 18'h2a5a5;
    pulse(3);
    chk(rvalid, 16'h0008);
    chk(rrow_q, 18'h2a5a5);
    pulse(4);
    chk(rvalid, 16'h0000);
    mw(3'h4, 14'h0002);
    mw(3'h5, 14'h1000);
    chk({psave, mr5}, {1'b1, 14'h0000});
    m_u.send(5'h00, 14'h0000, 1'b1, 0);
    repeat (30) @(posedge clk);
    chk(psave, 1'b0);
    test_done();
  end
  initial begin
    #100us;
    err_total++;
    test_done();
  end
endmodule : sdram_mode_reg_feature_decode_test
